// file: common/psds_map.vh
`ifndef PSDS_MAP_VH
`define PSDS_MAP_VH
// ********************
// Register offsets
// ********************
`define PSDS_OFF_PROF_THR    8'h00
`define PSDS_OFF_PROF_SKEW   8'h20
`define PSDS_OFF_CTRL        8'h40
`define PSDS_OFF_SEL         8'h44
`define PSDS_OFF_LIVE        8'h48
`define PSDS_OFF_IRQ_STAT    8'h4C
`define PSDS_OFF_IRQ_MASK    8'h50
`define PSDS_OFF_SKEW_OUT    8'h54
// ********************
// Field positions
// ********************
`define PSDS_CTRL_FAULT0_BIT 0
`define PSDS_CTRL_FAULT1_BIT 1
`define PSDS_SEL_CH1_LSB     4
// ********************
// Reset values
// ********************
`define PSDS_THR_RST         32'h00000000
`define PSDS_SKEW_RST        24'h000000
`define PSDS_CTRL_RST        2'h0
`define PSDS_SEL_RST         8'h00
`define PSDS_MASK_RST        2'h0
`endif

// file: src/psds_phase_step_detect.v
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "psds_map.vh"
module psds_phase_step_detect #(
	parameter PH_W  = 32,
	parameter PROFS = 8
) (
	input  wire              core_clk_i,
	input  wire              reset_i,
	input  wire [31:0]       haddr,
	input  wire [1:0]        htrans,
	input  wire              hwrite,
	input  wire [2:0]        hsize,
	input  wire              hsel,
	input  wire              hready,
	input  wire [31:0]       hwdata,
	output reg  [31:0]       hrdata,
	output reg               hreadyout,
	output reg               hresp,
	input  wire [1:0]        ph_valid_i,
	input  wire [2*PH_W-1:0] ph_err_i,
	input  wire [1:0]        freq_lock_i,
	input  wire [1:0]        ref_active_i,
	output reg  [1:0]        acq_restart_o,
	output reg  [1:0]        fast_acq_o,
	output reg  [1:0]        ref_mon_reset_o,
	output reg  [1:0]        step_live_o,
	output reg  [23:0]       skew0_o,
	output reg  [23:0]       skew1_o,
	output reg               irq_o
);
	// ********************
	// Register storage
	// ********************
	reg  [31:0] thr_reg  [0:PROFS-1];
	reg  [23:0] skew_reg [0:PROFS-1];
	reg  [1:0]  ctrl_reg;
	reg  [7:0]  sel_reg;
	reg  [1:0]  stat_reg;
	reg  [1:0]  mask_reg;
	reg  [1:0]  fast_en_reg;
	reg  [7:0]  addr_reg;
	reg         wr_reg;
	reg         rd_reg;
	wire        take;
	wire [1:0]  step_hit;
	wire        stat_rd;
	integer     i;
	reg  [31:0] rd_word;
	reg  [31:0] fwd_word;
	reg         fwd_hit;
	wire [7:0]  rd_addr;
	wire [1:0]  stat_next;

	assign take = hsel & hready & htrans[1];
	assign stat_rd = rd_reg & (addr_reg == `PSDS_OFF_IRQ_STAT);
	assign rd_addr = haddr[7:0];
	// New event beats the read clear
	assign stat_next = (stat_rd ? 2'h0 : stat_reg) | step_hit;

	// ********************
	// AHB slave, zero wait
	// ********************
	always @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			addr_reg  <= 8'h00;
			wr_reg    <= 1'b0;
			rd_reg    <= 1'b0;
		end
		else
		begin
			if (take)
			begin
				addr_reg <= rd_addr;
			end
			wr_reg   <= take & hwrite;
			rd_reg   <= take & ~hwrite;
		end
	end

	// ********************
	// Response, never stalls
	// ********************
	always @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	always @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			for (i = 0; i < PROFS; i = i + 1)
			begin
				thr_reg[i]  <= `PSDS_THR_RST;
				skew_reg[i] <= `PSDS_SKEW_RST;
			end
			ctrl_reg    <= `PSDS_CTRL_RST;
			sel_reg     <= `PSDS_SEL_RST;
			mask_reg    <= `PSDS_MASK_RST;
			fast_en_reg <= 2'h3;
		end
		else if (wr_reg)
		begin
			if (addr_reg < `PSDS_OFF_PROF_SKEW)
			begin
				thr_reg[addr_reg[4:2]] <= hwdata;
			end
			else if (addr_reg < `PSDS_OFF_CTRL)
			begin
				skew_reg[addr_reg[4:2]] <= hwdata[23:0];
			end
			else if (addr_reg == `PSDS_OFF_CTRL)
			begin
				ctrl_reg    <= hwdata[1:0];
				fast_en_reg <= hwdata[3:2];
			end
			else if (addr_reg == `PSDS_OFF_SEL)
			begin
				sel_reg <= hwdata[7:0];
			end
			else if (addr_reg == `PSDS_OFF_IRQ_MASK)
			begin
				mask_reg <= hwdata[1:0];
			end
			else
			begin
				// Read-only and unmapped words drop the write
			end
		end
	end

	// Lookahead decode keeps hrdata on a flop without a wait state
	always @*
	begin
		rd_word = 32'h00000000;
		if (rd_addr < `PSDS_OFF_PROF_SKEW)
		begin
			rd_word = thr_reg[rd_addr[4:2]];
		end
		else if (rd_addr < `PSDS_OFF_CTRL)
		begin
			rd_word = {8'h00, skew_reg[rd_addr[4:2]]};
		end
		else if (rd_addr == `PSDS_OFF_CTRL)
		begin
			rd_word = {28'h0000000, fast_en_reg, ctrl_reg};
		end
		else if (rd_addr == `PSDS_OFF_SEL)
		begin
			rd_word = {24'h000000, sel_reg};
		end
		else if (rd_addr == `PSDS_OFF_LIVE)
		begin
			rd_word = {30'h00000000, step_live_o};
		end
		else if (rd_addr == `PSDS_OFF_IRQ_STAT)
		begin
			rd_word = {30'h00000000, stat_next};
		end
		else if (rd_addr == `PSDS_OFF_IRQ_MASK)
		begin
			rd_word = {30'h00000000, mask_reg};
		end
		else if (rd_addr == `PSDS_OFF_SKEW_OUT)
		begin
			rd_word = {8'h00, skew0_o};
		end
	end

	// A write still in its data phase is not in the register yet: hand it on
	always @*
	begin
		fwd_hit  = 1'b0;
		fwd_word = 32'h00000000;
		if (wr_reg & (addr_reg == rd_addr))
		begin
			if (rd_addr < `PSDS_OFF_PROF_SKEW)
			begin
				fwd_hit  = 1'b1;
				fwd_word = hwdata;
			end
			else if (rd_addr < `PSDS_OFF_CTRL)
			begin
				fwd_hit  = 1'b1;
				fwd_word = {8'h00, hwdata[23:0]};
			end
			else if (rd_addr == `PSDS_OFF_CTRL)
			begin
				fwd_hit  = 1'b1;
				fwd_word = {28'h0000000, hwdata[3:0]};
			end
			else if (rd_addr == `PSDS_OFF_SEL)
			begin
				fwd_hit  = 1'b1;
				fwd_word = {24'h000000, hwdata[7:0]};
			end
			else if (rd_addr == `PSDS_OFF_IRQ_MASK)
			begin
				fwd_hit  = 1'b1;
				fwd_word = {30'h00000000, hwdata[1:0]};
			end
		end
	end

	// ********************
	// Read data launched from the address phase
	// ********************
	always @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			hrdata <= 32'h00000000;
		end
		else if (take & ~hwrite)
		begin
			if (fwd_hit)
			begin
				hrdata <= fwd_word;
			end
			else
			begin
				hrdata <= rd_word;
			end
		end
		else
		begin
			hrdata <= 32'h00000000;
		end
	end

	// ********************
	// Per-channel detector
	// ********************
	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1)
		begin : g_ch
			wire [2:0]      prof;
			wire [PH_W-1:0] smp;
			wire [PH_W-1:0] mag;
			wire [31:0]     thr;
			wire            armed;
			assign prof  = sel_reg[c*4 +: 3];
			assign smp   = ph_err_i[c*PH_W +: PH_W];
			// Most negative sample wraps to itself, still reads as huge
			assign mag   = smp[PH_W-1] ? (~smp + 1'b1) : smp;
			assign thr   = thr_reg[prof];
			// Lock and active reference gate the detector
			assign armed = (thr != 32'h00000000) & freq_lock_i[c] & ref_active_i[c];
			assign step_hit[c] = armed & ph_valid_i[c] & (mag > thr);

			always @(posedge core_clk_i or posedge reset_i)
			begin
				if (reset_i)
				begin
					acq_restart_o[c]   <= 1'b0;
					fast_acq_o[c]      <= 1'b0;
					ref_mon_reset_o[c] <= 1'b0;
					step_live_o[c]     <= 1'b0;
				end
				else
				begin
					acq_restart_o[c]   <= step_hit[c];
					fast_acq_o[c]      <= step_hit[c] & fast_en_reg[c];
					ref_mon_reset_o[c] <= step_hit[c] & ctrl_reg[c];
					if (~armed)
					begin
						step_live_o[c] <= 1'b0;
					end
					else if (ph_valid_i[c])
					begin
						step_live_o[c] <= mag > thr;
					end
				end
			end
		end
	endgenerate

	// ********************
	// Sticky status, read clears
	// ********************
	always @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			stat_reg <= 2'h0;
			irq_o    <= 1'b0;
		end
		else
		begin
			stat_reg <= stat_next;
			irq_o    <= |(stat_next & mask_reg);
		end
	end

	// ********************
	// Skew to references
	// ********************
	always @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			skew0_o <= `PSDS_SKEW_RST;
			skew1_o <= `PSDS_SKEW_RST;
		end
		else
		begin
			// Zero skew leaves the reference untouched
			skew0_o <= skew_reg[sel_reg[2:0]];
			skew1_o <= skew_reg[sel_reg[6:4]];
		end
	end
endmodule // psds_phase_step_detect

// file: testbench/psds_props.sv
`timescale 1ns/1ps
module psds_props (
	input wire       core_clk_i,
	input wire       reset_i,
	input wire       hreadyout,
	input wire       hresp,
	input wire [1:0] ph_valid_i,
	input wire [1:0] freq_lock_i,
	input wire [1:0] ref_active_i,
	input wire [1:0] acq_restart_o,
	input wire [1:0] fast_acq_o,
	input wire [1:0] ref_mon_reset_o,
	input wire [1:0] step_live_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	a_zero_wait: assert property (hreadyout) else $error("hreadyout low");
	a_resp_okay: assert property (!hresp) else $error("hresp not okay");
	for (genvar c = 0; c < 2; c++)
	begin : g_ch
		a_restart_cause: assert property (
			acq_restart_o[c] |-> $past(ph_valid_i[c] & freq_lock_i[c] & ref_active_i[c])) else $error("bad restart");
		a_no_sample_quiet: assert property (!ph_valid_i[c] |=> !acq_restart_o[c]) else $error("restart no sample");
		a_unlocked_quiet: assert property (
			!freq_lock_i[c] |=> !acq_restart_o[c] && !step_live_o[c]) else $error("active while unlocked");
		a_mon_with_restart: assert property (ref_mon_reset_o[c] |-> acq_restart_o[c]) else $error("lone mon");
		a_fast_with_restart: assert property (fast_acq_o[c] |-> acq_restart_o[c]) else $error("lone fast");
		a_live_on_restart: assert property (acq_restart_o[c] |-> step_live_o[c]) else $error("live low");
	end
endmodule // psds_props
bind psds_phase_step_detect psds_props i_props (.core_clk_i, .reset_i, .hreadyout, .hresp, .ph_valid_i,
	.freq_lock_i, .ref_active_i, .acq_restart_o, .fast_acq_o, .ref_mon_reset_o, .step_live_o);

// file: testbench/psds_partner.sv
`timescale 1ns/1ps
module psds_partner (
	input  wire         core_clk_i,
	output logic [1:0]  ph_valid_o = 2'h0,
	output logic [63:0] ph_err_o = 64'h0,
	output logic [1:0]  freq_lock_o = 2'h0,
	output logic [1:0]  ref_active_o = 2'h0
);
	task sample(input int c, input logic [31:0] e);
	begin
		@(posedge core_clk_i);
		ph_valid_o[c] <= 1'b1;
		ph_err_o[32*c+:32] <= e;
		@(posedge core_clk_i);
		ph_valid_o[c] <= 1'b0;
		// Stale word inverted so nothing leans on it
		ph_err_o[32*c+:32] <= ~e;
	end
	endtask
endmodule // psds_partner

// file: testbench/psds_phase_step_detect_tb_top.sv
`timescale 1ns/1ps
module psds_phase_step_detect_tb_top;
	logic        core_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0, hsel = 1'b0;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, irq;
	wire  [1:0]  vld, lck, act, rst, fst, mon, live;
	wire  [63:0] err;
	wire  [23:0] sk0, sk1;
	int          mismatches = 0, n_compared = 0;
	always #5 core_clk_i = ~core_clk_i;
	psds_phase_step_detect i_dut (.core_clk_i, .reset_i, .haddr, .htrans, .hwrite, .hsize(3'h2), .hsel,
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .ph_valid_i(vld), .ph_err_i(err),
		.freq_lock_i(lck), .ref_active_i(act), .acq_restart_o(rst), .fast_acq_o(fst),
		.ref_mon_reset_o(mon), .step_live_o(live), .skew0_o(sk0), .skew1_o(sk1), .irq_o(irq));
	psds_partner i_far (.core_clk_i, .ph_valid_o(vld), .ph_err_o(err), .freq_lock_o(lck), .ref_active_o(act));
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
	begin
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	end
	endtask
	task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
	begin
		@(posedge core_clk_i);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'b1;
		@(posedge core_clk_i);
		while (hreadyout !== 1'b1) @(posedge core_clk_i);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge core_clk_i);
		while (hreadyout !== 1'b1) @(posedge core_clk_i);
		rd = hrdata;
	end
	endtask
	task hit(input int c, input logic [31:0] e, input logic [3:0] x);
	begin
		i_far.sample(c, e);
		#1;
		chk("restart mon fast live", x, {rst[c], mon[c], fst[c], live[c]});
	end
	endtask
	task final_report;
	begin
		if (mismatches == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	initial
	begin
		repeat (4) @(posedge core_clk_i);
		reset_i <= 1'b0;
		bus(32'h0, 1'b0, 32'h0);
		chk("thr0", 32'h0, rd);
		bus(32'h2C, 1'b0, 32'h0);
		chk("skew3", 32'h0, rd);
		bus(32'h80, 1'b0, 32'h0);
		chk("unmapped", 32'h0, rd);
		i_far.freq_lock_o <= 2'h3;
		i_far.ref_active_o <= 2'h3;
		hit(0, 32'h7FFFFFFF, 4'h0);
		bus(32'h0, 1'b1, 32'h2EE0);
		hit(0, 32'h2EE0, 4'h0);
		hit(0, 32'hFFFFD11F, 4'hB);
		hit(0, 32'hFFFFD120, 4'h0);
		bus(32'h40, 1'b1, 32'h5);
		bus(32'h50, 1'b1, 32'h1);
		hit(0, 32'h2EE1, 4'hF);
		chk("irq", 32'h1, irq);
		bus(32'h4C, 1'b0, 32'h0);
		chk("stat", 32'h1, rd);
		@(posedge core_clk_i);
		#1;
		chk("irq", 32'h0, irq);
		bus(32'h50, 1'b1, 32'h0);
		hit(0, 32'h2EE1, 4'hF);
		chk("irq", 32'h0, irq);
		bus(32'h4C, 1'b0, 32'h0);
		bus(32'h4C, 1'b0, 32'h0);
		chk("stat", 32'h0, rd);
		i_far.freq_lock_o <= 2'h2;
		hit(0, 32'h7FFFFFFF, 4'h0);
		i_far.freq_lock_o <= 2'h3;
		i_far.ref_active_o <= 2'h2;
		hit(0, 32'h7FFFFFFF, 4'h0);
		i_far.ref_active_o <= 2'h3;
		bus(32'h44, 1'b1, 32'h10);
		bus(32'h4, 1'b1, 32'h5);
		bus(32'h24, 1'b1, 32'hFF7748);
		@(posedge core_clk_i);
		#1;
		chk("skew1_o", 32'hFF7748, sk1);
		chk("skew0_o", 32'h0, sk0);
		hit(1, 32'hFFFFFFFB, 4'h0);
		hit(1, 32'h6, 4'h9);
		final_report;
	end
	initial
	begin
		#100000;
		mismatches++;
		final_report;
	end
endmodule // psds_phase_step_detect_tb_top
